// ===== core/iolog_addr_seq.sv
`timescale 1ns/10ps
`include "iolog_consts.svh"
module iolog_addr_seq (
  input  wire logic  clk,
  input  wire logic  rst_b,
  iolog_seq_if.seq   sq
);
  import iolog_pkg::*;
  localparam logic [5:0] SEL_LO = 6'((`IOLOG_SEL_FIRST - `IOLOG_AREA_FIRST) >> 2);
  localparam logic [5:0] SEL_HI = 6'((`IOLOG_SEL_LAST - `IOLOG_AREA_FIRST) >> 2);
  localparam logic [5:0] COM_HI = 6'((`IOLOG_COMMON_LAST - `IOLOG_AREA_FIRST) >> 2);
  localparam logic [5:0] TOP    = `IOLOG_WORDS - 6'h01;

  iolog_mode_t mode;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= IOLOG_FULL;
    end else if (sq.start) begin
      mode <= sq.mode;
    end
  end

  // ascending order; partial jumps over the selector block
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sq.idx <= 6'h00;
    end else if (sq.start) begin
      sq.idx <= (sq.mode == IOLOG_SEL) ? SEL_LO : 6'h00;
    end else if (sq.step) begin
      sq.idx <= (mode == IOLOG_PARTIAL && sq.idx == COM_HI) ? TOP : sq.idx + 6'h01;
    end
  end

  assign sq.last   = (mode == IOLOG_SEL) ? (sq.idx == SEL_HI) : (sq.idx == TOP);
  assign sq.in_sel = (sq.idx >= SEL_LO) && (sq.idx <= SEL_HI);
endmodule // iolog_addr_seq

// ===== core/iolog_consts.svh
`ifndef IOLOG_CONSTS_SVH
`define IOLOG_CONSTS_SVH

`define IOLOG_REG_CTRL      8'h00
`define IOLOG_REG_STATUS    8'h04
`define IOLOG_REG_CHECK2    8'h08
`define IOLOG_REG_PSABASE   8'h0C

`define IOLOG_CTRL_ZFILL    8
`define IOLOG_CTRL_RESUME   9
`define IOLOG_CHK2_DWC      8
`define IOLOG_CTRL_RST      10'h000

`define IOLOG_SDR_TEMP      24'h000140
`define IOLOG_AREA_FIRST    24'h000144
`define IOLOG_AREA_LAST     24'h0001F4
`define IOLOG_COMMON_LAST   24'h0001C4
`define IOLOG_SEL_FIRST     24'h0001C8
`define IOLOG_SEL_LAST      24'h0001F0
`define IOLOG_PSW_MCHK      24'h000030
`define IOLOG_WORDS         6'h2D
`define IOLOG_ZERO_WORD     36'hF00000000

`define IOLOG_CC_OK         2'h0
`define IOLOG_CC_CHAN       2'h1

`endif

// ===== core/iolog_flag.sv
`timescale 1ns/10ps
module iolog_flag #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  // set beats clear so no event is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end
endmodule // iolog_flag

// ===== core/iolog_pkg.sv
package iolog_pkg;
  typedef enum logic [3:0] {
    IOLOG_IDLE     = 4'h0,
    IOLOG_CHKSTOP  = 4'h1,
    IOLOG_SAVE_SDR = 4'h3,
    IOLOG_WORDS    = 4'h2,
    IOLOG_CLR_SDR  = 4'h6,
    IOLOG_PSW      = 4'h7,
    IOLOG_RESPOND  = 4'h5,
    IOLOG_SEL_WAIT = 4'h4
  } iolog_state_t;

  typedef enum logic [1:0] {
    IOLOG_FULL    = 2'h0,
    IOLOG_PARTIAL = 2'h1,
    IOLOG_SEL     = 2'h2
  } iolog_mode_t;
endpackage

// ===== core/iolog_seq_if.sv
`timescale 1ns/10ps
interface iolog_seq_if;
  import iolog_pkg::*;
  logic        start;
  iolog_mode_t mode;
  logic        step;
  logic [5:0]  idx;
  logic        last;
  logic        in_sel;
  modport ctl (output start, mode, step, input idx, last, in_sel);
  modport seq (input start, mode, step, output idx, last, in_sel);
endinterface

// ===== core/iolog_sequencer.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "iolog_consts.svh"
module iolog_sequencer #(
  parameter int NCE = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   clu_check,
  input  wire logic                   sel_check,
  input  wire logic                   sel_iface_fault,
  input  wire logic                   probe_active,
  input  wire logic                   io_instr_active,
  input  wire logic                   xfer_active,
  input  wire logic                   proc_mode,
  input  wire logic                   dwc_logout,
  input  wire logic [$clog2(NCE)-1:0] dwc_src,
  input  wire logic                   permit_mchk,
  input  wire logic                   permit_io,
  input  wire logic [23:0]            psa_base,
  input  wire logic                   sel_involved,
  input  wire logic [35:0]            sdr_word,
  input  wire logic [35:0]            src_word,
  input  wire logic [35:0]            mchk_psw,
  output logic      [5:0]             src_idx,
  output logic                        st_req,
  output logic      [23:0]            st_addr,
  output logic      [35:0]            st_data,
  input  wire logic                   st_ack,
  output logic                        elc_pulse,
  output logic                        mchk_req,
  output logic                        io_int_req,
  output logic                        checkstop,
  output logic                        proc_suspend,
  output logic                        wait_loop,
  output logic                        response,
  output logic      [1:0]             resp_cc,
  output logic                        csw_bit45,
  output logic                        csw_bit46,
  output logic                        chan_reset
);
  import iolog_pkg::*;

  iolog_seq_if sq ();
  iolog_addr_seq u_seq (
    .clk   (clk),
    .rst_b (rst_b),
    .sq    (sq)
  );

  iolog_state_t     state;
  iolog_state_t     next_state;
  iolog_mode_t      mode;
  logic [NCE-1:0]   ccr_comm;
  logic             zfill;
  logic [23:0]      base;
  logic             psw_due;
  logic             chan_cc1;
  logic             sel_pend;
  logic             iface_kind;
  logic [31:0]      check2;
  logic             dwc_ok;
  logic             clu_trig;
  logic             sel_trig;
  logic             apb_wr;
  logic             apb_rd;
  logic             chk2_set;
  logic             word_done;
  logic             resume_wr;

  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = psel && penable && !pwrite;
  assign dwc_ok    = dwc_logout && ccr_comm[dwc_src];
  // a common check, or a selector check raised while a probe is active
  assign clu_trig  = clu_check || (sel_check && probe_active);
  assign sel_trig  = sel_check && !probe_active;
  assign word_done = st_req && st_ack;
  assign chk2_set  = dwc_ok && (state == IOLOG_IDLE || state == IOLOG_SEL_WAIT ||
                                state == IOLOG_CHKSTOP);
  assign resume_wr = apb_wr && paddr == `IOLOG_REG_CTRL && pwdata[`IOLOG_CTRL_RESUME];

  iolog_flag #(.W(1)) u_chk2 (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (chk2_set),
    .clr   (apb_wr && paddr == `IOLOG_REG_CHECK2 && pwdata[`IOLOG_CHK2_DWC]),
    .q     (check2[`IOLOG_CHK2_DWC])
  );
  assign check2[31:`IOLOG_CHK2_DWC+1] = '0;
  assign check2[`IOLOG_CHK2_DWC-1:0]  = '0;

  // register slave: no wait states, unmapped offsets flag an error
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ccr_comm <= '0;
      zfill    <= 1'b1;
    end else if (apb_wr && paddr == `IOLOG_REG_CTRL) begin
      ccr_comm <= pwdata[NCE-1:0];
      zfill    <= pwdata[`IOLOG_CTRL_ZFILL];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          `IOLOG_REG_CTRL:    prdata <= 32'({zfill, ccr_comm});
          `IOLOG_REG_STATUS:  prdata <= 32'({mode, wait_loop, checkstop, state});
          `IOLOG_REG_CHECK2:  prdata <= check2;
          `IOLOG_REG_PSABASE: prdata <= 32'(base);
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // main sequence
  always_comb begin
    next_state = state;
    unique case (state)
      IOLOG_IDLE: begin
        if (dwc_ok) begin
          next_state = IOLOG_SAVE_SDR;
        end else if (clu_trig) begin
          next_state = IOLOG_CHKSTOP;
        end else if (sel_trig && xfer_active) begin
          next_state = IOLOG_SEL_WAIT;
        end else if (sel_trig) begin
          next_state = IOLOG_SAVE_SDR;
        end
      end
      IOLOG_CHKSTOP: begin
        if (dwc_ok || permit_mchk) begin
          next_state = IOLOG_SAVE_SDR;
        end
      end
      IOLOG_SEL_WAIT: begin
        if (clu_check) begin
          next_state = IOLOG_CHKSTOP;
        end else if (permit_io || dwc_ok) begin
          next_state = IOLOG_SAVE_SDR;
        end
      end
      IOLOG_SAVE_SDR: begin
        if (word_done) begin
          next_state = IOLOG_WORDS;
        end
      end
      IOLOG_WORDS: begin
        if (clu_check && mode == IOLOG_SEL) begin
          next_state = IOLOG_CHKSTOP;
        end else if (word_done && sq.last) begin
          next_state = IOLOG_CLR_SDR;
        end
      end
      IOLOG_CLR_SDR: begin
        if (word_done) begin
          next_state = psw_due ? IOLOG_PSW : IOLOG_RESPOND;
        end
      end
      IOLOG_PSW: begin
        if (word_done) begin
          next_state = IOLOG_RESPOND;
        end
      end
      IOLOG_RESPOND: begin
        next_state = IOLOG_IDLE;
      end
      default: begin
        next_state = IOLOG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IOLOG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // kind of logout and its options, set when the sequence is entered, changed later only when a selector logout escalates
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode       <= IOLOG_FULL;
      psw_due    <= 1'b0;
      chan_cc1   <= 1'b0;
      iface_kind <= 1'b0;
      sel_pend   <= 1'b0;
    end else if (state == IOLOG_IDLE) begin
      psw_due    <= clu_check && proc_mode && !dwc_ok;
      iface_kind <= sel_iface_fault;
      chan_cc1   <= sel_trig && io_instr_active && !xfer_active;
      sel_pend   <= sel_trig;
      if (dwc_ok || clu_trig) begin
        mode <= (sel_involved || zfill) ? IOLOG_FULL : IOLOG_PARTIAL;
      end else if (sel_trig) begin
        mode <= IOLOG_SEL;
      end
    end else if ((state == IOLOG_SEL_WAIT || state == IOLOG_WORDS) && mode == IOLOG_SEL) begin
      if (clu_check || dwc_ok) begin
        // an escalated logout covers everything, channel included; one raised by dwc_ok alone in IOLOG_WORDS still ends after the selector words
        mode     <= IOLOG_FULL;
        psw_due  <= clu_check && proc_mode;
        chan_cc1 <= 1'b0;
      end
    end
  end

  // storage base: taken with the grant, or the one already on the bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base <= '0;
    end else if ((state == IOLOG_CHKSTOP && (permit_mchk || dwc_ok)) ||
                 (state == IOLOG_SEL_WAIT && (permit_io || dwc_ok)) ||
                 (state == IOLOG_IDLE && (dwc_ok || (sel_trig && !xfer_active)))) begin
      base <= psa_base;
    end
  end

  assign sq.mode  = mode;
  assign sq.start = (state == IOLOG_SAVE_SDR) && word_done;
  assign sq.step  = (state == IOLOG_WORDS) && word_done && !sq.last;
  assign src_idx  = sq.idx;

  // one storage write per word; data is held until acknowledged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_req  <= 1'b0;
      st_addr <= '0;
      st_data <= '0;
    end else if (word_done) begin
      st_req <= 1'b0;
    end else if (!st_req) begin
      unique case (state)
        IOLOG_SAVE_SDR: begin
          st_req  <= 1'b1;
          st_addr <= base + `IOLOG_SDR_TEMP;
          st_data <= sdr_word;
        end
        IOLOG_WORDS: begin
          st_req  <= 1'b1;
          st_addr <= base + `IOLOG_AREA_FIRST + {16'h0000, sq.idx, 2'b00};
          // parity travels with the word untouched
          st_data <= (sq.in_sel && mode != IOLOG_SEL && !sel_involved) ?
                     `IOLOG_ZERO_WORD : src_word;
        end
        IOLOG_CLR_SDR: begin
          st_req  <= 1'b1;
          st_addr <= base + `IOLOG_SDR_TEMP;
          st_data <= `IOLOG_ZERO_WORD;
        end
        IOLOG_PSW: begin
          st_req  <= 1'b1;
          st_addr <= `IOLOG_PSW_MCHK;
          st_data <= mchk_psw;
        end
        default: begin
          st_req  <= 1'b0;
        end
      endcase
    end
  end

  // requests toward the computing element
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      elc_pulse  <= 1'b0;
      mchk_req   <= 1'b0;
      io_int_req <= 1'b0;
      checkstop  <= 1'b0;
    end else begin
      elc_pulse  <= (state != IOLOG_CHKSTOP) && (next_state == IOLOG_CHKSTOP) && !dwc_ok;
      mchk_req   <= (next_state == IOLOG_CHKSTOP);
      io_int_req <= (next_state == IOLOG_SEL_WAIT);
      checkstop  <= (next_state == IOLOG_CHKSTOP);
    end
  end

  // response only after the final write is acknowledged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      response  <= 1'b0;
      resp_cc   <= `IOLOG_CC_OK;
      csw_bit45 <= 1'b0;
      csw_bit46 <= 1'b0;
      chan_reset <= 1'b0;
    end else begin
      response   <= (state == IOLOG_RESPOND);
      resp_cc    <= (state == IOLOG_RESPOND && chan_cc1) ? `IOLOG_CC_CHAN : `IOLOG_CC_OK;
      csw_bit45  <= (state == IOLOG_RESPOND) && mode == IOLOG_SEL && !iface_kind;
      csw_bit46  <= (state == IOLOG_RESPOND) && mode == IOLOG_SEL && iface_kind;
      chan_reset <= (state == IOLOG_RESPOND) && (sel_pend || mode == IOLOG_SEL);
    end
  end

  // processor mode: suspended through a channel logout, halted after a common one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_suspend <= 1'b0;
      wait_loop    <= 1'b0;
    end else begin
      // mode left over from the last logout is not trusted while still idle
      proc_suspend <= (state != IOLOG_IDLE) && (next_state != IOLOG_IDLE) &&
                      (next_state != IOLOG_CHKSTOP) && mode == IOLOG_SEL;
      if (state == IOLOG_RESPOND && mode != IOLOG_SEL) begin
        wait_loop <= 1'b1;
      end else if (resume_wr) begin
        wait_loop <= 1'b0;
      end
    end
  end
endmodule // iolog_sequencer

// ===== sim/iolog_ce_model.sv
`timescale 1ns/10ps
module iolog_ce_model #(
  parameter logic [23:0] BASE = 24'h004000
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        mchk_req,
  input  wire logic        io_int_req,
  input  wire logic        io_masked,
  input  wire logic [5:0]  src_idx,
  output logic      [35:0] src_word,
  output logic      [23:0] psa_base,
  output logic             permit_mchk,
  output logic             permit_io,
  input  wire logic        st_req,
  input  wire logic [23:0] st_addr,
  input  wire logic [35:0] st_data,
  output logic             st_ack
);
  logic [2:0]  mdly;
  logic [2:0]  idly;
  logic [1:0]  wcnt;
  logic [23:0] wa[$];
  logic [35:0] wd[$];
  // parity nibble follows the index, so regenerated parity shows up
  assign src_word = {src_idx[3:0], 26'h0, src_idx};
  assign psa_base = BASE;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdly <= 3'h0;
      idly <= 3'h0;
      permit_mchk <= 1'b0;
      permit_io <= 1'b0;
    end else begin
      mdly <= {mdly[1:0], mchk_req};
      idly <= {idly[1:0], io_int_req};
      // a grant comes late, as the current instruction must finish first
      permit_mchk <= mchk_req & mdly[2] & !permit_mchk;
      permit_io <= io_int_req & idly[2] & !io_masked & !permit_io;
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ack <= 1'b0;
      wcnt <= 2'h0;
    end else if (st_req && st_ack) begin
      wa.push_back(st_addr);
      wd.push_back(st_data);
      st_ack <= 1'b0;
      wcnt <= 2'($urandom_range(3));
    end else begin
      st_ack <= st_req && wcnt == 2'h0;
      if (wcnt != 2'h0) wcnt <= wcnt - 2'h1;
    end
  end
endmodule // iolog_ce_model

// ===== sim/iolog_sequencer_monitor.sv
`timescale 1ns/10ps
module iolog_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        clu_check,
  input wire logic        sel_check,
  input wire logic        permit_mchk,
  input wire logic        permit_io,
  input wire logic [23:0] psa_base,
  input wire logic        st_req,
  input wire logic [23:0] st_addr,
  input wire logic [35:0] st_data,
  input wire logic        st_ack,
  input wire logic        elc_pulse,
  input wire logic        mchk_req,
  input wire logic        io_int_req,
  input wire logic        wait_loop,
  input wire logic        response,
  input wire logic [1:0]  resp_cc,
  input wire logic        csw_bit45,
  input wire logic        csw_bit46,
  input wire logic        chan_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [23:0] off;
  assign off = st_addr - psa_base;
  a_req_holds: assert property (st_req && !st_ack |=> st_req && $stable({st_addr, st_data}))
    else $error("store request changed before ack");
  a_addr_in_area: assert property (st_req |-> st_addr == 24'h000030 ||
    (off >= 24'h140 && off <= 24'h1F4 && off[1:0] == 2'h0))
    else $error("store outside logout area");
  a_resp_after_ack: assert property ($rose(response) |->
    $past(st_ack) || $past(st_ack, 2) || $past(st_ack, 3))
    else $error("response not after final ack");
  a_resp_one_cycle: assert property (response |=> !response)
    else $error("response longer than one cycle");
  a_elc_one_cycle: assert property (elc_pulse |=> !elc_pulse)
    else $error("element check not a pulse");
  a_mchk_has_cause: assert property ($rose(mchk_req) |-> $past(clu_check | sel_check) ||
    $past(clu_check | sel_check, 2) || $past(clu_check | sel_check, 3))
    else $error("machine check request without check");
  a_mchk_drops: assert property (mchk_req && permit_mchk |=> !mchk_req)
    else $error("machine check request kept after permit");
  a_no_store_waiting: assert property ((mchk_req && $past(mchk_req)) ||
    (io_int_req && $past(io_int_req)) |-> !st_req)
    else $error("store before permit");
  a_csw_with_resp: assert property (csw_bit45 || csw_bit46 || chan_reset |-> response)
    else $error("status bit without response");
  a_cc1_marks_csw: assert property (response && resp_cc == 2'h1 |-> csw_bit45 ^ csw_bit46)
    else $error("cc 1 without one status bit");
  a_wait_after_clu: assert property (response && !chan_reset |-> ##[0:1] wait_loop)
    else $error("no wait loop after common logout");
  cover property (response && resp_cc == 2'h1);
  cover property (elc_pulse);
  cover property (io_int_req && permit_io);
endmodule // iolog_monitor

bind iolog_sequencer iolog_monitor u_mon (.clk, .rst_b, .clu_check, .sel_check, .permit_mchk,
  .permit_io, .psa_base, .st_req, .st_addr, .st_data, .st_ack, .elc_pulse, .mchk_req,
  .io_int_req, .wait_loop, .response, .resp_cc, .csw_bit45, .csw_bit46, .chan_reset);

// ===== sim/iolog_sequencer_tb.sv
`timescale 1ns/10ps
module iolog_sequencer_tb;
  import iolog_pkg::*;
  localparam logic [23:0] BASE = 24'h004000;
  localparam logic [2:0]  EV_DWC = 3'h4;
  localparam logic [2:0]  EV_CLU = 3'h2;
  localparam logic [2:0]  EV_SEL = 3'h1;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, configuration_control_register;
  logic [31:0] pwdata, prdata, r;
  logic        clu_check, sel_check, sel_iface_fault, probe_active, io_instr_active;
  logic        xfer_active, proc_mode, dwc_logout, permit_mchk, permit_io, sel_involved;
  logic [2:0]  dwc_src;
  logic [23:0] psa_base, st_addr;
  logic [35:0] sdr_word, src_word, mchk_psw, st_data;
  logic [5:0]  src_idx;
  logic        st_req, st_ack, elc_pulse, mchk_req, io_int_req, checkstop, proc_suspend;
  logic        wait_loop, response, csw_bit45, csw_bit46, chan_reset, io_masked;
  logic [1:0]  resp_cc;
  logic        mchk_seen, susp_seen;
  int          error_cnt, check_count, s;

  iolog_sequencer dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clu_check, .sel_check, .sel_iface_fault, .probe_active,
    .io_instr_active, .xfer_active, .proc_mode, .dwc_logout, .dwc_src, .permit_mchk,
    .permit_io, .psa_base, .sel_involved, .sdr_word, .src_word, .mchk_psw, .src_idx, .st_req,
    .st_addr, .st_data, .st_ack, .elc_pulse, .mchk_req, .io_int_req, .checkstop,
    .proc_suspend, .wait_loop, .response, .resp_cc, .csw_bit45, .csw_bit46, .chan_reset);
  iolog_ce_model #(.BASE(BASE)) u_ce (.clk, .rst_b, .mchk_req, .io_int_req, .io_masked,
    .src_idx, .src_word, .psa_base, .permit_mchk, .permit_io, .st_req, .st_addr, .st_data,
    .st_ack);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (mchk_req === 1'b1) mchk_seen <= 1'b1;
    if (proc_suspend === 1'b1) susp_seen <= 1'b1;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wt(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    wt(pready, 20);
    r = prdata;
    check(pslverr, er);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ctrl(input logic zf, input logic rs);
    apb(1'b1, 8'h00, {22'h0, rs, zf, configuration_control_register}, 1'b0);
  endtask
  // reads the wait loop flag, then releases it
  task automatic wl(input logic zf);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    check(r[5], 1'b1);
    ctrl(zf, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    check(r[5], 1'b0);
  endtask
  task automatic prep;
    u_ce.wa.delete();
    u_ce.wd.delete();
    mchk_seen <= 1'b0;
    susp_seen <= 1'b0;
    sdr_word <= 36'({$urandom, $urandom});
    mchk_psw <= 36'({$urandom, $urandom});
  endtask
  task automatic pulse(input logic [2:0] ev);
    {dwc_logout, clu_check, sel_check} <= ev;
    @(posedge clk);
    {dwc_logout, clu_check, sel_check} <= 3'h0;
  endtask
  // logword index of the j-th area word in each kind of logout
  function automatic int exp_idx(input iolog_mode_t md, input int j);
    if (md == IOLOG_SEL) return 33 + j;
    return (md == IOLOG_PARTIAL && j > 32) ? 44 : j;
  endfunction
  // uninvolved selector words are zero with good parity
  function automatic logic [35:0] exp_word(input int k);
    if (k > 32 && k < 44 && !sel_involved) return 36'hF00000000;
    return {k[3:0], 26'h0, k[5:0]};
  endfunction
  task automatic fin(input iolog_mode_t md, input logic program_status_word, input logic [1:0] cc);
    int j, k, p;
    logic [35:0] z, m;
    logic sl;
    sl = (md == IOLOG_SEL);
    j = 0;
    p = 0;
    z = 36'hF00000000;
    wt(response, 3000);
    check(resp_cc, cc);
    check({csw_bit45 | csw_bit46, chan_reset}, {sl, sl});
    if (sl) check(csw_bit46, sel_iface_fault);
    if (!sl) check(u_ce.wa[0], BASE + 24'h140);
    if (!sl) check(u_ce.wd[0], sdr_word);
    foreach (u_ce.wa[i]) begin
      if (u_ce.wa[i] == 24'h000030) begin
        check(u_ce.wd[i], mchk_psw);
        p++;
      end else if (u_ce.wa[i] == BASE + 24'h140) begin
        z = u_ce.wd[i];
      end else begin
        k = exp_idx(md, j);
        m = exp_word(k);
        check(u_ce.wa[i], BASE + 24'h144 + 24'(4 * k));
        check(u_ce.wd[i], m);
        j++;
      end
    end
    check(j, sl ? 11 : (md == IOLOG_PARTIAL) ? 34 : 45);
    check(p, program_status_word);
    check(z, 36'hF00000000);
    repeat (3) @(posedge clk);
  endtask

  initial begin
    {clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {clu_check, sel_check, sel_iface_fault, probe_active, io_instr_active} = '0;
    {xfer_active, proc_mode, dwc_logout, dwc_src, sel_involved, io_masked} = '0;
    {sdr_word, mchk_psw, error_cnt, check_count} = '0;
    r = $urandom(32'hD933);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    check(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0, 1'b1);
    check(r, 32'h0);
    s = $urandom_range(7);
    configuration_control_register = 8'($urandom) & ~(8'h01 << s);
    dwc_src <= 3'(s);
    ctrl(1'b1, 1'b1);
    apb(1'b0, 8'h00, 32'h0, 1'b0);
    check(r, {23'h0, 1'b1, configuration_control_register});
    prep();
    pulse(EV_DWC);
    repeat (20) @(posedge clk);
    check(u_ce.wa.size(), 0);
    configuration_control_register[s] = 1'b1;
    ctrl(1'b1, 1'b0);
    sel_involved <= 1'b1;
    prep();
    pulse(EV_DWC);
    fin(IOLOG_FULL, 1'b0, 2'h0);
    check(mchk_seen, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    check(r[8], 1'b1);
    apb(1'b1, 8'h08, 32'h100, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    check(r[8], 1'b0);
    wl(1'b0);
    sel_involved <= 1'b0;
    prep();
    pulse(EV_DWC);
    fin(IOLOG_PARTIAL, 1'b0, 2'h0);
    wl(1'b1);
    proc_mode <= 1'b1;
    prep();
    pulse(EV_CLU);
    wt(elc_pulse, 10);
    check(checkstop, 1'b1);
    fin(IOLOG_FULL, 1'b1, 2'h0);
    check(mchk_seen, 1'b1);
    wl(1'b1);
    io_instr_active <= 1'b1;
    sel_involved <= 1'b1;
    sel_iface_fault <= 1'($urandom);
    prep();
    pulse(EV_SEL);
    fin(IOLOG_SEL, 1'b0, 2'h1);
    check(susp_seen, 1'b1);
    io_instr_active <= 1'b0;
    xfer_active <= 1'b1;
    io_masked <= 1'b1;
    prep();
    pulse(EV_SEL);
    repeat (30) @(posedge clk);
    check(u_ce.wa.size(), 0);
    check(io_int_req, 1'b1);
    io_masked <= 1'b0;
    fin(IOLOG_SEL, 1'b0, 2'h0);
    xfer_active <= 1'b0;
    probe_active <= 1'b1;
    proc_mode <= 1'b0;
    prep();
    pulse(EV_SEL);
    fin(IOLOG_FULL, 1'b0, 2'h0);
    check(mchk_seen, 1'b1);
    test_done();
  end
endmodule // iolog_sequencer_tb
